// ==== verilog/sysctrl_pkg.sv ====
// constants, field masks and carrier types for the system-controller register map
package sysctrl_pkg;

  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_IRQ_ENABLE_CLEAR = 8'h00;
  localparam logic [7:0] OFF_IRQ_ENABLE_SET = 8'h04;
  localparam logic [7:0] OFF_FLL_VALUE = 8'h28;
  localparam logic [7:0] OFF_FLL_MULTIPLIER = 8'h2C;
  localparam logic [7:0] OFF_FLL_SYNC = 8'h30;
  localparam logic [7:0] OFF_BROWNOUT_3V3_CTRL = 8'h34;
  localparam logic [7:0] OFF_REGULATOR_CTRL = 8'h3C;
  localparam logic [7:0] OFF_REFERENCE_CTRL = 8'h40;
  localparam logic [7:0] OFF_PLL_RATIO = 8'h48;
  localparam logic [7:0] OFF_PLL_CTRL_B = 8'h4C;
  localparam logic [7:0] OFF_PLL_STATUS = 8'h50;

  // ---------------------------------------------------------------
  // implemented-bit masks; bits outside a mask read zero, except the live difference in the loop value upper half
  // ---------------------------------------------------------------
  localparam logic [31:0] MASK_IRQ_ENABLE = 32'h0003_8FFF;
  localparam logic [31:0] MASK_FLL_VALUE_WR = 32'h0000_FFFF;
  localparam logic [31:0] MASK_FLL_MULTIPLIER = 32'hFFFF_FFFF;
  localparam logic [31:0] MASK_BROWNOUT = 32'h003F_F35E;
  localparam logic [31:0] MASK_REGULATOR = 32'h0000_2040;
  localparam logic [31:0] MASK_REFERENCE = 32'h07FF_0006;
  localparam logic [31:0] MASK_PLL_RATIO = 32'h000F_0FFF;
  localparam logic [31:0] MASK_PLL_CTRL_B = 32'h07FF_173F;
  localparam logic [31:0] MASK_PLL_STATUS = 32'h0000_000F;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] RST_IRQ_ENABLE = 32'h0000_0000;
  localparam logic [31:0] RST_FLL_VALUE = 32'h0000_0000;
  localparam logic [31:0] RST_FLL_MULTIPLIER = 32'h0000_0000;
  localparam logic [31:0] RST_BROWNOUT = 32'h0000_0000;
  localparam logic [31:0] RST_REGULATOR = 32'h0000_0000;
  localparam logic [31:0] RST_REFERENCE = 32'h0000_0000;
  localparam logic [31:0] RST_PLL_RATIO = 32'h0000_0000;
  localparam logic [31:0] RST_PLL_CTRL_B = 32'h0000_0000;
  localparam logic [3:0] RST_PLL_STATUS = 4'h0;

  // ---------------------------------------------------------------
  // field positions and widths
  // ---------------------------------------------------------------
  localparam int unsigned IRQ_SRC_W = 18;
  localparam int unsigned FLL_READ_REQUEST_BIT = 7;
  localparam int unsigned FLL_DIFF_W = 16;
  localparam int unsigned PLL_STATUS_LOCK = 0;
  localparam int unsigned PLL_STATUS_CLOCK_READY = 1;
  localparam int unsigned PLL_STATUS_ENABLE = 2;
  localparam int unsigned PLL_STATUS_DIV = 3;

  // ---------------------------------------------------------------
  // byte-enable patterns and timing
  // ---------------------------------------------------------------
  localparam logic [3:0] BE_WORD = 4'hF;
  localparam logic [3:0] BE_HALF_LO = 4'h3;
  localparam logic [3:0] BE_HALF_HI = 4'hC;
  localparam logic [3:0] BE_BYTE0 = 4'h1;
  localparam logic [3:0] BE_BYTE1 = 4'h2;
  localparam logic [3:0] BE_BYTE2 = 4'h4;
  localparam logic [3:0] BE_BYTE3 = 4'h8;
  localparam int unsigned SYNC_LEN = 4;
  localparam int unsigned SYNC_CNT_W = 8;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } bus_req_t;

  typedef struct packed {
    logic ack;
    logic err;
    logic [31:0] rdata;
  } bus_resp_t;

  typedef struct packed {
    logic [IRQ_SRC_W-1:0] irq_enable;
    logic [31:0] fll_value;
    logic [31:0] fll_multiplier;
    logic [31:0] brownout_3v3_ctrl;
    logic [31:0] regulator_ctrl;
    logic [31:0] reference_ctrl;
    logic [31:0] pll_ratio;
    logic [31:0] pll_ctrl_b;
  } cfg_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FLL_SYNC,
    ST_BOD_SYNC
  } sync_state_t;

endpackage

// ==== verilog/sysctrl_register_map.sv ====
// register bank for the clock-loop, brown-out, regulator, reference and pll controls
// Overview of operation
// - each register is 8, 16 or 32 bits wide as its map entry shows
// - single indivisible 8, 16 and 32 bit bus accesses are accepted
// - bytes and halves of 32-bit registers, bytes of 16-bit ones, reachable alone
// - loop value and multiplier reads wait for a completed read sync while the loop is enabled; brown-out writes complete first, then sync
// - protectable registers ignore writes while access protection is enabled
// - writing zero to an enable-clear bit leaves that enable unchanged
// - writing one to an enable-clear bit clears that interrupt enable
// - enable at one raises interrupt request whenever matching flag is set
// - enable at zero means flag produces no interrupt request
// - enable bits 17,16,15 pll; bits 11 to 8 brown-out and loop reference
// - enable bits 7 to 0 loop locks, bounds, ready and oscillator readies
// - loop sync register bit 7 is read request starting loop read sync
// - pll status bit0 lock, bit1 clock ready, bit2 enabled, bit3 divider
`timescale 1ns/10ps
module sysctrl_register_map
  import sysctrl_pkg::*;
#(
  parameter int unsigned SYNC_CYCLES = SYNC_LEN
)
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire bus_req_t bus_req,
  output bus_resp_t bus_resp,
  input wire logic protect_en,
  input wire logic fll_enabled,
  input wire logic [FLL_DIFF_W-1:0] fll_diff,
  input wire logic [IRQ_SRC_W-1:0] irq_flags,
  input wire logic pll_lock,
  input wire logic pll_clock_ready,
  input wire logic pll_enabled,
  input wire logic pll_div_engaged,
  output cfg_t cfg,
  output logic fll_ready,
  output logic bod_sync_ready,
  output logic irq_req
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // only whole words, aligned halves and single bytes are legal
  function automatic logic legal_be(input logic [3:0] be);
    legal_be = (be == BE_WORD) || (be == BE_HALF_LO) || (be == BE_HALF_HI) ||
               (be == BE_BYTE0) || (be == BE_BYTE1) || (be == BE_BYTE2) || (be == BE_BYTE3);
  endfunction

  // word match only: lanes come from the byte enables, so the low address bits are ignored
  function automatic logic hit_word(input logic [7:0] addr, input logic [7:0] off);
    hit_word = addr[7:2] == off[7:2];
  endfunction

  // byte-lane merge keeping unwritten lanes and reserved bits untouched
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wdata,
                                        input logic [3:0] be, input logic [31:0] mask);
    logic [31:0] sel;
    sel = lane_mask(be) & mask;
    merge = (old & ~sel) | (wdata & sel);
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  cfg_t cfg_q;
  cfg_t cfg_d;
  bus_resp_t resp_q;
  bus_resp_t resp_d;
  sync_state_t state_q;
  sync_state_t state_d;
  logic [SYNC_CNT_W-1:0] cnt_q;
  logic [SYNC_CNT_W-1:0] cnt_d;
  logic fll_ready_q;
  logic fll_ready_d;
  logic bod_sync_ready_q;
  logic bod_sync_ready_d;
  logic irq_req_q;
  logic [3:0] pll_status_q;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  wire hit_ie_clr = hit_word(bus_req.addr, OFF_IRQ_ENABLE_CLEAR);
  wire hit_ie_set = hit_word(bus_req.addr, OFF_IRQ_ENABLE_SET);
  wire hit_fll_val = hit_word(bus_req.addr, OFF_FLL_VALUE);
  wire hit_fll_mul = hit_word(bus_req.addr, OFF_FLL_MULTIPLIER);
  wire hit_fll_sync = hit_word(bus_req.addr, OFF_FLL_SYNC);
  wire hit_bod = hit_word(bus_req.addr, OFF_BROWNOUT_3V3_CTRL);
  wire hit_regulator_ctrl = hit_word(bus_req.addr, OFF_REGULATOR_CTRL);
  wire hit_vref = hit_word(bus_req.addr, OFF_REFERENCE_CTRL);
  wire hit_pll_ratio = hit_word(bus_req.addr, OFF_PLL_RATIO);
  wire hit_pll_ctrl_b = hit_word(bus_req.addr, OFF_PLL_CTRL_B);
  wire hit_pll_status = hit_word(bus_req.addr, OFF_PLL_STATUS);
  wire hit_any = hit_ie_clr | hit_ie_set | hit_fll_val | hit_fll_mul | hit_fll_sync | hit_bod |
                 hit_regulator_ctrl | hit_vref | hit_pll_ratio | hit_pll_ctrl_b | hit_pll_status;
  wire hit_writable = hit_any & ~hit_pll_status;
  wire be_ok = legal_be(bus_req.be);

  // ---------------------------------------------------------------
  // access acceptance and stalls
  // ---------------------------------------------------------------
  wire fll_cfg_hit = hit_fll_val | hit_fll_mul;
  // a loop read without a completed read request holds the bus; a stopped loop never does
  wire fll_stall = fll_cfg_hit & ~bus_req.write & fll_enabled & ~fll_ready_q;
  wire idle = state_q == ST_IDLE;
  // the held request is still valid in the ack cycle, so it is not taken twice
  wire accept = bus_req.valid & idle & ~fll_stall & ~resp_q.ack;
  wire prot_block = bus_req.write & protect_en & hit_writable;
  wire wr_en = accept & bus_req.write & be_ok & hit_writable & ~protect_en;
  wire acc_err = accept & (~hit_any | ~be_ok | prot_block);
  wire [31:0] wmask = lane_mask(bus_req.be);
  wire [31:0] ie_bits = bus_req.wdata & wmask & MASK_IRQ_ENABLE;
  wire read_req_wr = wr_en & hit_fll_sync & bus_req.be[0] & bus_req.wdata[FLL_READ_REQUEST_BIT];
  wire bod_wr = wr_en & hit_bod;
  wire fll_cfg_wr = wr_en & fll_cfg_hit;
  wire sync_done = cnt_q == SYNC_CNT_W'(SYNC_CYCLES - 1);
  // a held loop read starts the sync itself, so a read without a prior request still completes
  wire stall_start = bus_req.valid & fll_stall & ~resp_q.ack;

  // ---------------------------------------------------------------
  // per-register write strobes
  // ---------------------------------------------------------------
  wire wr_ie_clr = wr_en & hit_ie_clr;
  wire wr_ie_set = wr_en & hit_ie_set;
  wire wr_fll_val = wr_en & hit_fll_val;
  wire wr_fll_mul = wr_en & hit_fll_mul;
  wire wr_regulator_ctrl = wr_en & hit_regulator_ctrl;
  wire wr_vref = wr_en & hit_vref;
  wire wr_pll_ratio = wr_en & hit_pll_ratio;
  wire wr_pll_ctrl_b = wr_en & hit_pll_ctrl_b;

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  always_comb begin
    cfg_d = cfg_q;
    if (wr_ie_clr) begin
      // zeros leave enables alone, ones clear them
      cfg_d.irq_enable = cfg_q.irq_enable & ~ie_bits[IRQ_SRC_W-1:0];
    end
    if (wr_ie_set) begin
      cfg_d.irq_enable = cfg_q.irq_enable | ie_bits[IRQ_SRC_W-1:0];
    end
    if (wr_fll_val) begin
      // the difference field is measured, never stored from the bus
      cfg_d.fll_value = merge(cfg_q.fll_value, bus_req.wdata, bus_req.be, MASK_FLL_VALUE_WR);
    end
    if (wr_fll_mul) begin
      cfg_d.fll_multiplier = merge(cfg_q.fll_multiplier, bus_req.wdata, bus_req.be, MASK_FLL_MULTIPLIER);
    end
    if (bod_wr) begin
      cfg_d.brownout_3v3_ctrl = merge(cfg_q.brownout_3v3_ctrl, bus_req.wdata, bus_req.be, MASK_BROWNOUT);
    end
    if (wr_regulator_ctrl) begin
      cfg_d.regulator_ctrl = merge(cfg_q.regulator_ctrl, bus_req.wdata, bus_req.be, MASK_REGULATOR);
    end
    if (wr_vref) begin
      cfg_d.reference_ctrl = merge(cfg_q.reference_ctrl, bus_req.wdata, bus_req.be, MASK_REFERENCE);
    end
    if (wr_pll_ratio) begin
      cfg_d.pll_ratio = merge(cfg_q.pll_ratio, bus_req.wdata, bus_req.be, MASK_PLL_RATIO);
    end
    if (wr_pll_ctrl_b) begin
      cfg_d.pll_ctrl_b = merge(cfg_q.pll_ctrl_b, bus_req.wdata, bus_req.be, MASK_PLL_CTRL_B);
    end
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  // the measured difference is never stored; it is read live into the upper half
  wire [31:0] rd_ie = {{(32 - IRQ_SRC_W){1'b0}}, cfg_q.irq_enable};
  wire [31:0] rd_fll_val = {fll_diff, cfg_q.fll_value[31 - FLL_DIFF_W:0]};
  wire [31:0] rd_status = {28'h000_0000, pll_status_q} & MASK_PLL_STATUS;
  logic [31:0] rd_word;

  always_comb begin
    rd_word = 32'h0000_0000;
    if (hit_ie_clr || hit_ie_set) begin
      rd_word = rd_ie;
    end
    if (hit_fll_val) begin
      rd_word = rd_fll_val;
    end
    if (hit_fll_mul) begin
      rd_word = cfg_q.fll_multiplier;
    end
    if (hit_bod) begin
      rd_word = cfg_q.brownout_3v3_ctrl;
    end
    if (hit_regulator_ctrl) begin
      rd_word = cfg_q.regulator_ctrl;
    end
    if (hit_vref) begin
      rd_word = cfg_q.reference_ctrl;
    end
    if (hit_pll_ratio) begin
      rd_word = cfg_q.pll_ratio;
    end
    if (hit_pll_ctrl_b) begin
      rd_word = cfg_q.pll_ctrl_b;
    end
    if (hit_pll_status) begin
      rd_word = rd_status;
    end
  end

  // unaddressed lanes, write-only and failed accesses return zero
  always_comb begin
    resp_d.ack = accept;
    resp_d.err = acc_err;
    resp_d.rdata = 32'h0000_0000;
    if (accept && !bus_req.write && be_ok && hit_any) begin
      resp_d.rdata = rd_word & wmask;
    end
  end

  // ---------------------------------------------------------------
  // synchronisation sequencer
  // ---------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    fll_ready_d = fll_ready_q;
    bod_sync_ready_d = bod_sync_ready_q;
    if (fll_cfg_wr) begin
      fll_ready_d = 1'b0;
    end
    case (state_q)
      ST_IDLE: begin
        cnt_d = '0;
        if (read_req_wr || stall_start) begin
          state_d = ST_FLL_SYNC;
          fll_ready_d = 1'b0;
        end else if (bod_wr) begin
          state_d = ST_BOD_SYNC;
          bod_sync_ready_d = 1'b0;
        end
      end
      ST_FLL_SYNC: begin
        cnt_d = cnt_q + 1'b1;
        if (sync_done) begin
          state_d = ST_IDLE;
          fll_ready_d = 1'b1;
        end
      end
      ST_BOD_SYNC: begin
        cnt_d = cnt_q + 1'b1;
        if (sync_done) begin
          state_d = ST_IDLE;
          bod_sync_ready_d = 1'b1;
        end
      end
      default: begin
        state_d = ST_IDLE;
        cnt_d = '0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // flip-flops
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_q.irq_enable <= RST_IRQ_ENABLE[IRQ_SRC_W-1:0];
      cfg_q.fll_value <= RST_FLL_VALUE;
      cfg_q.fll_multiplier <= RST_FLL_MULTIPLIER;
      cfg_q.brownout_3v3_ctrl <= RST_BROWNOUT;
      cfg_q.regulator_ctrl <= RST_REGULATOR;
      cfg_q.reference_ctrl <= RST_REFERENCE;
      cfg_q.pll_ratio <= RST_PLL_RATIO;
      cfg_q.pll_ctrl_b <= RST_PLL_CTRL_B;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      resp_q <= '0;
    end else begin
      resp_q <= resp_d;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // nothing is pending out of reset, so the brown-out side starts ready
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      fll_ready_q <= 1'b0;
      bod_sync_ready_q <= 1'b1;
    end else begin
      fll_ready_q <= fll_ready_d;
      bod_sync_ready_q <= bod_sync_ready_d;
    end
  end

  // status is sampled so a read returns a stable snapshot
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pll_status_q <= RST_PLL_STATUS;
    end else begin
      pll_status_q[PLL_STATUS_LOCK] <= pll_lock;
      pll_status_q[PLL_STATUS_CLOCK_READY] <= pll_clock_ready;
      pll_status_q[PLL_STATUS_ENABLE] <= pll_enabled;
      pll_status_q[PLL_STATUS_DIV] <= pll_div_engaged;
    end
  end

  // registered so the request line never glitches while flags and enables settle
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_req_q <= 1'b0;
    end else begin
      irq_req_q <= |(irq_flags & cfg_q.irq_enable);
    end
  end

  assign bus_resp = resp_q;
  assign cfg = cfg_q;
  assign fll_ready = fll_ready_q;
  assign bod_sync_ready = bod_sync_ready_q;
  assign irq_req = irq_req_q;

endmodule

// ==== verif/sysctrl_register_map_properties.sv ====
// concurrent property checker for the system-controller register bank
`timescale 1ns/10ps
module sysctrl_register_map_properties
  import sysctrl_pkg::*;
#(
  parameter int unsigned SYNC_CYCLES = SYNC_LEN
)
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire bus_req_t bus_req,
  input wire bus_resp_t bus_resp,
  input wire logic protect_en,
  input wire logic fll_enabled,
  input wire logic [FLL_DIFF_W-1:0] fll_diff,
  input wire logic [IRQ_SRC_W-1:0] irq_flags,
  input wire logic pll_lock,
  input wire logic pll_clock_ready,
  input wire logic pll_enabled,
  input wire logic pll_div_engaged,
  input wire cfg_t cfg,
  input wire logic fll_ready,
  input wire logic bod_sync_ready,
  input wire logic irq_req
);
  // two spare cycles cover the hand-off into and out of the sync sequencer
  localparam int SYNC_MAX = SYNC_CYCLES + 2;
  logic [31:0] lane_mask;
  assign lane_mask = {{8{bus_req.be[3]}}, {8{bus_req.be[2]}}, {8{bus_req.be[1]}}, {8{bus_req.be[0]}}};

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  a_ack_single_pulse: assert property (bus_resp.ack |=> !bus_resp.ack)
    else $error("ack longer than one cycle");
  a_err_needs_ack: assert property (bus_resp.err |-> bus_resp.ack)
    else $error("err without ack");
  a_irq_req_tracks: assert property (
    irq_req == |($past(irq_flags) & $past(cfg.irq_enable)))
    else $error("irq request does not follow flags and enables");
  a_clear_ones_only: assert property (
    bus_resp.ack && !bus_resp.err && $past(bus_req.write) && $past(bus_req.addr[7:2]) == 6'h00
    |-> cfg.irq_enable == ($past(cfg.irq_enable) & ~$past(lane_mask[17:0] & bus_req.wdata[17:0])))
    else $error("enable clear wrong");
  a_reserved_enable_zero: assert property (cfg.irq_enable[14:12] == 3'h0)
    else $error("reserved enable bits set");
  a_protect_blocks_write: assert property (
    bus_resp.ack && $past(protect_en) && $past(bus_req.write)
    |-> $stable(cfg.irq_enable) && $stable(cfg.pll_ratio))
    else $error("protected write changed a register");
  a_bod_sync_starts: assert property (
    bus_resp.ack && !bus_resp.err && $past(bus_req.write) && $past(bus_req.addr) == OFF_BROWNOUT_3V3_CTRL
    |-> !bod_sync_ready)
    else $error("brown-out write did not start sync");
  a_bod_sync_bounded: assert property ($fell(bod_sync_ready) |-> ##[1:SYNC_MAX] bod_sync_ready)
    else $error("brown-out sync too long");
  a_fll_ready_bounded: assert property (
    bus_resp.ack && !bus_resp.err && $past(bus_req.write) && $past(bus_req.addr) == OFF_FLL_SYNC &&
    $past(bus_req.wdata[7]) && $past(bus_req.be[0]) && fll_enabled |-> ##[1:SYNC_MAX] fll_ready)
    else $error("loop read sync never completed");
  a_status_upper_zero: assert property (
    bus_resp.ack && !$past(bus_req.write) && $past(bus_req.addr[7:2]) == OFF_PLL_STATUS[7:2]
    |-> bus_resp.rdata[31:4] == 28'h0)
    else $error("pll status upper bits not zero");

  cover property (bus_resp.ack && bus_resp.err);
  cover property (irq_req);
  cover property ($rose(fll_ready));
endmodule

bind sysctrl_register_map sysctrl_register_map_properties #(.SYNC_CYCLES(SYNC_CYCLES)) chk_u (
  .core_clk(core_clk), .rst_b(rst_b), .bus_req(bus_req), .bus_resp(bus_resp), .protect_en(protect_en),
  .fll_enabled(fll_enabled), .fll_diff(fll_diff), .irq_flags(irq_flags), .pll_lock(pll_lock),
  .pll_clock_ready(pll_clock_ready), .pll_enabled(pll_enabled), .pll_div_engaged(pll_div_engaged),
  .cfg(cfg), .fll_ready(fll_ready), .bod_sync_ready(bod_sync_ready), .irq_req(irq_req));

// ==== verif/sysctrl_register_map_tb.sv ====
// self-checking bench for the system-controller register bank
`timescale 1ns/10ps
module sysctrl_register_map_tb
  import sysctrl_pkg::*;
;
  localparam logic [15:0] DIFF = 16'h5A3C;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  bus_req_t bus_req = '0;
  bus_resp_t bus_resp;
  logic protect_en = 1'b0;
  logic fll_enabled = 1'b1;
  logic [IRQ_SRC_W-1:0] irq_flags = '0;
  logic [3:0] pll_in = 4'h0;
  cfg_t cfg;
  logic fll_ready;
  logic bod_sync_ready;
  logic irq_req;
  int err_count = 0;
  int samples_checked = 0;
  logic [31:0] rd;
  logic er;
  logic [7:0] offs [8];
  logic [31:0] exps [8];

  always #20 core_clk = ~core_clk;

  sysctrl_register_map dut_u (.core_clk(core_clk), .rst_b(rst_b), .bus_req(bus_req), .bus_resp(bus_resp),
    .protect_en(protect_en), .fll_enabled(fll_enabled), .fll_diff(DIFF), .irq_flags(irq_flags),
    .pll_lock(pll_in[0]), .pll_clock_ready(pll_in[1]), .pll_enabled(pll_in[2]), .pll_div_engaged(pll_in[3]),
    .cfg(cfg), .fll_ready(fll_ready), .bod_sync_ready(bod_sync_ready), .irq_req(irq_req));

  task automatic end_sim;
    if (err_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // request held until ack is sampled; stalled loop reads make the wait long
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [3:0] be, input logic [31:0] wd);
    int n = 0;
    @(posedge core_clk);
    bus_req <= {1'b1, wr, a, be, wd};
    do begin
      @(posedge core_clk);
      n++;
    end while (bus_resp.ack !== 1'b1 && n < 40);
    rd = bus_resp.rdata;
    er = bus_resp.err;
    bus_req.valid <= 1'b0;
    if (n >= 40) begin
      err_count++;
      $display("[FAIL] %0t ns: no ack", $time);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [3:0] be, input logic [31:0] exp);
    xfer(1'b0, a, be, 32'h0);
    check(rd, exp);
  endtask

  task automatic wr_chk(input logic [7:0] a, input logic [3:0] be, input logic [31:0] wd, input logic exp_err);
    xfer(1'b1, a, be, wd);
    check({31'h0, er}, {31'h0, exp_err});
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    end_sim;
  end

  initial begin
    offs = '{OFF_PLL_RATIO, OFF_PLL_CTRL_B, OFF_REFERENCE_CTRL, OFF_REGULATOR_CTRL, OFF_BROWNOUT_3V3_CTRL,
      OFF_FLL_MULTIPLIER, OFF_FLL_VALUE, OFF_PLL_STATUS};
    exps = '{MASK_PLL_RATIO, MASK_PLL_CTRL_B, MASK_REFERENCE, MASK_REGULATOR, MASK_BROWNOUT,
      MASK_FLL_MULTIPLIER, {DIFF, MASK_FLL_VALUE_WR[15:0]}, 32'h0};
    repeat (4) @(posedge core_clk);
    check({29'h0, bod_sync_ready, fll_ready, irq_req}, 32'h4);
    rst_b <= 1'b1;
    rd_chk(OFF_IRQ_ENABLE_CLEAR, BE_WORD, RST_IRQ_ENABLE);
    rd_chk(OFF_PLL_RATIO, BE_WORD, RST_PLL_RATIO);
    for (int i = 0; i < 8; i++) begin
      wr_chk(offs[i], BE_WORD, 32'hFFFF_FFFF, 1'b0);
      rd_chk(offs[i], BE_WORD, exps[i]);
    end
    wr_chk(OFF_PLL_RATIO, BE_WORD, 32'h0, 1'b0);
    wr_chk(OFF_PLL_RATIO, BE_BYTE1, 32'hFFFF_FFFF, 1'b0);
    rd_chk(OFF_PLL_RATIO, BE_WORD, 32'h0000_0F00);
    wr_chk(OFF_PLL_RATIO, BE_HALF_HI, 32'hFFFF_FFFF, 1'b0);
    rd_chk(OFF_PLL_RATIO, BE_BYTE2, 32'h000F_0000);
    wr_chk(OFF_REGULATOR_CTRL, BE_HALF_LO, 32'h0, 1'b0);
    wr_chk(OFF_REGULATOR_CTRL, BE_BYTE1, 32'hFFFF_FFFF, 1'b0);
    rd_chk(OFF_REGULATOR_CTRL, BE_HALF_LO, 32'h0000_2000);
    protect_en <= 1'b1;
    wr_chk(OFF_PLL_RATIO, BE_WORD, 32'h0, 1'b1);
    wr_chk(OFF_IRQ_ENABLE_SET, BE_WORD, 32'hFFFF_FFFF, 1'b1);
    protect_en <= 1'b0;
    rd_chk(OFF_PLL_RATIO, BE_WORD, 32'h000F_0F00);
    check(cfg.pll_ratio, 32'h000F_0F00);
    rd_chk(OFF_IRQ_ENABLE_CLEAR, BE_WORD, 32'h0);
    rd_chk(8'h60, BE_WORD, 32'h0);
    check({31'h0, er}, 32'h1);
    wr_chk(OFF_PLL_RATIO, 4'h5, 32'h0, 1'b1);
    wr_chk(OFF_IRQ_ENABLE_SET, BE_WORD, 32'hFFFF_FFFF, 1'b0);
    rd_chk(OFF_IRQ_ENABLE_CLEAR, BE_WORD, 32'h0003_8FFF);
    wr_chk(OFF_IRQ_ENABLE_CLEAR, BE_WORD, 32'h0, 1'b0);
    rd_chk(OFF_IRQ_ENABLE_CLEAR, BE_WORD, 32'h0003_8FFF);
    wr_chk(OFF_IRQ_ENABLE_CLEAR, BE_BYTE2, 32'h0002_0000, 1'b0);
    wr_chk(OFF_IRQ_ENABLE_CLEAR, BE_BYTE0, 32'h0000_00A5, 1'b0);
    wr_chk(OFF_IRQ_ENABLE_CLEAR, BE_BYTE1, 32'h0000_7F00, 1'b0);
    rd_chk(OFF_IRQ_ENABLE_CLEAR, BE_HALF_LO, 32'h0000_805A);
    rd_chk(OFF_IRQ_ENABLE_CLEAR, BE_HALF_HI, 32'h0001_0000);
    check({14'h0, cfg.irq_enable}, 32'h0001_805A);
    irq_flags <= 18'h0_0010;
    repeat (3) @(posedge core_clk);
    check({31'h0, irq_req}, 32'h1);
    // bits 17 and 0 were cleared above, so these flags must stay silent
    irq_flags <= 18'h2_0001;
    repeat (3) @(posedge core_clk);
    check({31'h0, irq_req}, 32'h0);
    irq_flags <= 18'h0_8000;
    wr_chk(OFF_IRQ_ENABLE_CLEAR, BE_BYTE1, 32'h0000_8000, 1'b0);
    repeat (3) @(posedge core_clk);
    check({31'h0, irq_req}, 32'h0);
    for (int i = 0; i < 4; i++) begin
      pll_in <= 4'h1 << i;
      repeat (2) @(posedge core_clk);
      rd_chk(OFF_PLL_STATUS, BE_BYTE0, 32'h1 << i);
    end
    wr_chk(OFF_FLL_SYNC, BE_BYTE0, 32'h0000_0080, 1'b0);
    check({31'h0, fll_ready}, 32'h0);
    for (int k = 0; k < 40 && fll_ready !== 1'b1; k++) @(posedge core_clk);
    check({31'h0, fll_ready}, 32'h1);
    rd_chk(OFF_FLL_VALUE, BE_HALF_HI, {DIFF, 16'h0});
    wr_chk(OFF_BROWNOUT_3V3_CTRL, BE_WORD, 32'h0000_0002, 1'b0);
    check({31'h0, bod_sync_ready}, 32'h0);
    rd_chk(OFF_BROWNOUT_3V3_CTRL, BE_WORD, 32'h0000_0002);
    // a stopped loop must answer at once and start no sync
    fll_enabled <= 1'b0;
    wr_chk(OFF_FLL_MULTIPLIER, BE_WORD, 32'h1234_5678, 1'b0);
    rd_chk(OFF_FLL_MULTIPLIER, BE_WORD, 32'h1234_5678);
    check({31'h0, fll_ready}, 32'h0);
    end_sim;
  end
endmodule
